//--- src/dsmm_defines.svh
`ifndef DSMM_DEFINES_SVH
`define DSMM_DEFINES_SVH

// Monitor selection codes
`define DSMM_MON_SPEED 4'h0
`define DSMM_MON_SPEED_CMD 4'h1
`define DSMM_MON_TORQUE_CMD 4'h2
`define DSMM_MON_UPHASE_PULSE 4'h3
`define DSMM_MON_ELEC_ANGLE 4'h4
`define DSMM_MON_INT_FLAGS 4'h5
`define DSMM_MON_IN_FLAGS 4'h6
`define DSMM_MON_POS_ERROR 4'h8
`define DSMM_MON_REF_PULSES 4'h9

// Register offsets (byte addresses)
`define DSMM_REG_SELECT 8'h00
`define DSMM_REG_CONFIG 8'h04
`define DSMM_REG_WINDOW 8'h08
`define DSMM_REG_VALUE 8'h0c
`define DSMM_REG_STATUS 8'h10

// Config register fields
`define DSMM_CFG_POSTYPE 0
`define DSMM_CFG_REVERSE 1
`define DSMM_CFG_BRAKE_SEL 2
`define DSMM_CFG_ERR_X100 3
`define DSMM_CFG_CONTACT_SPD 4
`define DSMM_CFG_RESET 8'h00

// In-position window reset value, one pulse
`define DSMM_WINDOW_RESET 16'h0001

// Scale factor for position error
`define DSMM_ERR_SCALE 32'h00000064

`endif

//--- src/dsmm_pkg.sv
package dsmm_pkg;
	// Control type of the amplifier build
	typedef enum logic {
		DSMM_SPEED_TORQUE,
		DSMM_POSITION
	} dsmm_ctrl_type_t;
	// Status of a sampled monitor selection
	typedef enum logic [1:0] {
		DSMM_SEL_OK,
		DSMM_SEL_UNAVAIL,
		DSMM_SEL_UNKNOWN
	} dsmm_sel_state_t;
endpackage

//--- src/dsmm_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser with agreement filter
module dsmm_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Pin side
	input wire logic [WIDTH-1:0] pinIn,
	// Filtered level
	output logic [WIDTH-1:0] levelOut
);
	logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

	// New level only once the second and third stage agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
		end
	end

	// Shift chain; first stage feeds only the second
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			lvl_q <= '0;
		end else begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	assign levelOut = lvl_q;
endmodule
`default_nettype wire

//--- src/dsmm_pulse_cnt.sv
`timescale 1ns/1ns
`default_nettype none
// Edge-driven counter with synchronous clear
module dsmm_pulse_cnt #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Count control
	input wire logic level,
	input wire logic clear,
	// Count value
	output logic [WIDTH-1:0] count
);
	logic prev_q, prev_d;
	logic [WIDTH-1:0] cnt_q, cnt_d;

	// Count rising edges; clear wins, wraps naturally at full scale
	always_comb begin
		prev_d = level;
		cnt_d = cnt_q;
		if (clear) begin
			cnt_d = '0;
		end else if (level && !prev_q) begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	// State registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			prev_q <= 1'b0;
			cnt_q <= '0;
		end else begin
			prev_q <= prev_d;
			cnt_q <= cnt_d;
		end
	end

	assign count = cnt_q;
endmodule
`default_nettype wire

//--- src/dsmm_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "dsmm_defines.svh"
// What this block does
// - Monitor selectable and live while motor runs
// - Monitor set follows configured control type
// - Monitor 02 shows torque percent
// - Monitor 03 counts pulses since U edge
// - Monitor 00 speed, 01 speed command
// - Monitor 05 packs flags bits 1..20
// - Bit 3 reverse mode from config/pin
// - Bit 5 coincide or in-position by type
// - Bits 7,8 torque limits, contact speed
// - Bits 10-15 encoder and commutation phases
// - Bits 16-19 servo-on, P input, overtravel
// - Monitor 08 error scaled x1 or x100
// - Monitor 09 reference pulses wrap 65535
// - Monitor 06 pulse, sign, clear bits
// - One config bit selects bit 4 source
// - In-position while error within window
module dsmm_monitor (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// Internal quantities, same clock
	input wire logic signed [15:0] motorSpeed,
	input wire logic signed [15:0] speedCommand,
	input wire logic signed [15:0] torquePercent,
	input wire logic [15:0] elecAngle,
	input wire logic signed [31:0] posErrorPulses,
	input wire logic dynBrakeOn,
	input wire logic gainModeOn,
	input wire logic motorPowerOn,
	input wire logic servoAlarmOut,
	input wire logic rotationDetectOut,
	input wire logic brakeInterlockOut,
	input wire logic speedCoincideOut,
	input wire logic encOutA,
	input wire logic encOutB,
	input wire logic encOutC,
	input wire logic incrementalEnc,
	input wire logic servoOnCmd,
	// Pins from outside the clock domain
	input wire logic dirPin,
	input wire logic fwdTorqueLimitIn,
	input wire logic revTorqueLimitIn,
	input wire logic encU,
	input wire logic encV,
	input wire logic encW,
	input wire logic propControlIn,
	input wire logic fwdOvertravelIn,
	input wire logic revOvertravelIn,
	input wire logic absDataRequestIn,
	input wire logic refPulseIn,
	input wire logic pulseSignIn,
	input wire logic errorClearIn,
	input wire logic extEncA,
	input wire logic extEncB,
	input wire logic extEncC,
	// Display word and derived outputs
	output logic [31:0] monitorValue,
	output logic inPositionOut,
	output logic reverseMode
);
	localparam int NPIN = 16;

	// Software-visible state
	logic [3:0] sel_q, sel_d;
	logic [7:0] cfg_q, cfg_d;
	logic [15:0] win_q, win_d;
	logic [31:0] val_q, val_d;
	logic [31:0] rd_q, rd_d;
	dsmm_pkg::dsmm_sel_state_t st_q, st_d;

	// Synchronised pins
	logic [NPIN-1:0] pinRaw, pinLvl;
	logic [15:0] uCount, refCount;
	logic [19:0] intFlags, inFlags;
	logic posType, errAbsLow, uLvl, pulseLvl;
	logic uPrev_q, uRise; // U-phase edge detector
	logic [31:0] errAbs;
	dsmm_pkg::dsmm_ctrl_type_t ctrlType;

	assign pinRaw = {extEncC, extEncB, extEncA, errorClearIn, pulseSignIn,
		refPulseIn, absDataRequestIn, revOvertravelIn, fwdOvertravelIn,
		propControlIn, encW, encV, encU, revTorqueLimitIn, fwdTorqueLimitIn, dirPin};

	// Pins cross into the clock domain through three stages
	dsmm_sync #(.WIDTH(NPIN)) uSync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.pinIn(pinRaw),
		.levelOut(pinLvl)
	);

	assign uLvl = pinLvl[3];
	assign pulseLvl = pinLvl[10];

	// Encoder pulses since last U-phase edge; a rising U clears
	dsmm_pulse_cnt #(.WIDTH(16)) uUphase (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.level(encOutA),
		.clear(uRise),
		.count(uCount)
	);

	// Received reference pulses, wrapping 0..65535
	dsmm_pulse_cnt #(.WIDTH(16)) uRefCnt (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.level(pulseLvl),
		.clear(1'b0),
		.count(refCount)
	);

	// Previous U level resets low like the idle pin, so no false edge
	assign uRise = uLvl && !uPrev_q;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			uPrev_q <= 1'b0;
		end else begin
			uPrev_q <= uLvl;
		end
	end

	// Control type from configuration
	assign posType = cfg_q[`DSMM_CFG_POSTYPE];
	assign ctrlType = posType ? dsmm_pkg::DSMM_POSITION : dsmm_pkg::DSMM_SPEED_TORQUE;

	// Magnitude of position error for the in-position compare
	assign errAbs = posErrorPulses[31] ? 32'(-posErrorPulses) : 32'(posErrorPulses);
	assign errAbsLow = errAbs <= {16'h0000, win_q};
	assign inPositionOut = errAbsLow;

	// Reverse mode by config bit or direction pin
	assign reverseMode = cfg_q[`DSMM_CFG_REVERSE] | pinLvl[0];

	// Is a monitor number offered for this control type
	function automatic logic selAvail(input logic [3:0] s, input logic pt);
		if (s == `DSMM_MON_SPEED || s == `DSMM_MON_TORQUE_CMD || s == `DSMM_MON_UPHASE_PULSE ||
			s == `DSMM_MON_ELEC_ANGLE || s == `DSMM_MON_INT_FLAGS) begin
			selAvail = 1'b1;
		end else if (s == `DSMM_MON_SPEED_CMD) begin
			selAvail = !pt;
		end else if (s == `DSMM_MON_IN_FLAGS || s == `DSMM_MON_POS_ERROR || s == `DSMM_MON_REF_PULSES) begin
			selAvail = pt;
		end else begin
			selAvail = 1'b0;
		end
	endfunction

	// Internal status flags, bit n at index n-1
	always_comb begin
		intFlags = '0;
		intFlags[0] = servoAlarmOut;
		intFlags[1] = dynBrakeOn;
		intFlags[2] = reverseMode;
		intFlags[3] = cfg_q[`DSMM_CFG_BRAKE_SEL] ? brakeInterlockOut : rotationDetectOut;
		intFlags[4] = posType ? inPositionOut : speedCoincideOut;
		intFlags[5] = gainModeOn;
		intFlags[6] = cfg_q[`DSMM_CFG_CONTACT_SPD] ? 1'b1 : pinLvl[1];
		intFlags[7] = pinLvl[2];
		intFlags[8] = motorPowerOn;
		intFlags[9] = encOutA;
		intFlags[10] = encOutB;
		intFlags[11] = encOutC;
		intFlags[12] = incrementalEnc & pinLvl[3];
		intFlags[13] = incrementalEnc & pinLvl[4];
		intFlags[14] = incrementalEnc & pinLvl[5];
		intFlags[15] = servoOnCmd;
		intFlags[16] = pinLvl[6];
		intFlags[17] = pinLvl[7];
		intFlags[18] = pinLvl[8];
		intFlags[19] = posType ? 1'b0 : pinLvl[9];
	end

	// Input flags; unused positions stay zero
	always_comb begin
		inFlags = '0;
		inFlags[0] = pinLvl[10];
		inFlags[1] = pinLvl[11];
		inFlags[2] = pinLvl[12];
		inFlags[12] = pinLvl[13];
		inFlags[13] = pinLvl[14];
		inFlags[14] = pinLvl[15];
	end

	// Register writes and next sampled value
	always_comb begin
		sel_d = sel_q;
		cfg_d = cfg_q;
		win_d = win_q;
		// Writes take effect at any time, motor running or not
		if (regWr) begin
			if (regAddr == `DSMM_REG_SELECT) begin
				sel_d = regWdata[3:0];
			end else if (regAddr == `DSMM_REG_CONFIG) begin
				cfg_d = regWdata[7:0];
			end else if (regAddr == `DSMM_REG_WINDOW) begin
				win_d = regWdata[15:0];
			end
		end
		// One word sampled per clock so all bits agree
		val_d = '0;
		st_d = dsmm_pkg::DSMM_SEL_OK;
		if (!selAvail(sel_q, ctrlType == dsmm_pkg::DSMM_POSITION)) begin
			// Unknown only when neither build type offers the number
			st_d = (selAvail(sel_q, 1'b0) || selAvail(sel_q, 1'b1)) ?
				dsmm_pkg::DSMM_SEL_UNAVAIL : dsmm_pkg::DSMM_SEL_UNKNOWN;
		end else begin
			case (sel_q)
				`DSMM_MON_SPEED: val_d = 32'(motorSpeed);
				`DSMM_MON_SPEED_CMD: val_d = 32'(speedCommand);
				`DSMM_MON_TORQUE_CMD: val_d = 32'(torquePercent);
				`DSMM_MON_UPHASE_PULSE: val_d = {16'h0000, uCount};
				`DSMM_MON_ELEC_ANGLE: val_d = {16'h0000, elecAngle};
				`DSMM_MON_INT_FLAGS: val_d = {12'h000, intFlags};
				`DSMM_MON_IN_FLAGS: val_d = {12'h000, inFlags};
				// Coarse scale divides error by one hundred
				`DSMM_MON_POS_ERROR: val_d = cfg_q[`DSMM_CFG_ERR_X100] ?
					32'($signed(posErrorPulses) / $signed(`DSMM_ERR_SCALE)) : posErrorPulses;
				`DSMM_MON_REF_PULSES: val_d = {16'h0000, refCount};
				default: val_d = '0;
			endcase
		end
	end

	// Read data, valid the cycle after the strobe only
	always_comb begin
		rd_d = '0;
		if (regRd) begin
			if (regAddr == `DSMM_REG_SELECT) begin
				rd_d = {28'h0000000, sel_q};
			end else if (regAddr == `DSMM_REG_CONFIG) begin
				rd_d = {24'h000000, cfg_q};
			end else if (regAddr == `DSMM_REG_WINDOW) begin
				rd_d = {16'h0000, win_q};
			end else if (regAddr == `DSMM_REG_VALUE) begin
				rd_d = val_q;
			end else if (regAddr == `DSMM_REG_STATUS) begin
				rd_d = {28'h0000000, inPositionOut, reverseMode, st_q};
			end else begin
				rd_d = '0;
			end
		end
	end

	// State registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sel_q <= `DSMM_MON_SPEED;
			cfg_q <= `DSMM_CFG_RESET;
			win_q <= `DSMM_WINDOW_RESET;
			val_q <= '0;
			rd_q <= '0;
			st_q <= dsmm_pkg::DSMM_SEL_OK;
		end else begin
			sel_q <= sel_d;
			cfg_q <= cfg_d;
			win_q <= win_d;
			val_q <= val_d;
			rd_q <= rd_d;
			st_q <= st_d;
		end
	end

	assign regRdata = rd_q;
	assign monitorValue = val_q;

	// Checks
	a_sel_speed: assert property (@(posedge ref_clk) disable iff (!nrst)
		(sel_q == `DSMM_MON_SPEED) |=> (monitorValue == 32'($past(motorSpeed))))
		else $error("speed monitor mismatch");
	a_torque_view: assert property (@(posedge ref_clk) disable iff (!nrst)
		(sel_q == `DSMM_MON_TORQUE_CMD) |=> (monitorValue == 32'($past(torquePercent))))
		else $error("torque monitor mismatch");
	// Window written on the signed error, independent of the magnitude path
	a_inpos_window: assert property (@(posedge ref_clk) disable iff (!nrst)
		inPositionOut == ($signed(posErrorPulses) <= $signed({16'h0000, win_q}) &&
		$signed(posErrorPulses) >= -$signed({16'h0000, win_q})))
		else $error("in-position wrong");
	a_bit20_pos: assert property (@(posedge ref_clk) disable iff (!nrst)
		(posType && sel_q == `DSMM_MON_INT_FLAGS) |=> !monitorValue[19])
		else $error("bit 20 set in position type");
	a_type_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
		(!posType && $stable(posType) && sel_q == `DSMM_MON_POS_ERROR) |=> (monitorValue == 32'h0))
		else $error("position monitor in speed type");
	a_sel_write: assert property (@(posedge ref_clk) disable iff (!nrst)
		(regWr && regAddr == `DSMM_REG_SELECT) |=> (sel_q == $past(regWdata[3:0])))
		else $error("selection not taken");
	a_bit4_brake: assert property (@(posedge ref_clk) disable iff (!nrst)
		(sel_q == `DSMM_MON_INT_FLAGS && cfg_q[`DSMM_CFG_BRAKE_SEL]) |=>
		(monitorValue[3] == $past(brakeInterlockOut)))
		else $error("bit 4 not brake interlock");
	a_bit4_rotate: assert property (@(posedge ref_clk) disable iff (!nrst)
		(sel_q == `DSMM_MON_INT_FLAGS && !cfg_q[`DSMM_CFG_BRAKE_SEL]) |=>
		(monitorValue[3] == $past(rotationDetectOut)))
		else $error("bit 4 not rotation detect");
	a_in_unused: assert property (@(posedge ref_clk) disable iff (!nrst)
		(sel_q == `DSMM_MON_IN_FLAGS) |=> (monitorValue[11:3] == 9'h000 && monitorValue[31:15] == 17'h00000))
		else $error("unused input bits set");
	c_flags: cover property (@(posedge ref_clk) disable iff (!nrst) sel_q == `DSMM_MON_INT_FLAGS && posType);
	c_err100: cover property (@(posedge ref_clk) disable iff (!nrst)
		sel_q == `DSMM_MON_POS_ERROR && cfg_q[`DSMM_CFG_ERR_X100]);
	c_refwrap: cover property (@(posedge ref_clk) disable iff (!nrst) refCount == 16'hffff);
endmodule
`default_nettype wire

//--- bench/dsmm_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// Far-side pin source for the asynchronous inputs
module dsmm_pin_model (
	// Levels asked for by the bench
	input wire logic [15:0] pinReq,
	// Levels seen on the pins
	output logic [15:0] pinOut
);
	// The skew keeps pin edges away from the sampling edge, as real wiring would
	assign #37 pinOut = pinReq;
endmodule
`default_nettype wire

//--- bench/drive_status_monitor_mux_bench.sv
`timescale 1ns/1ns
`default_nettype none
module drive_status_monitor_mux_bench;
	// Clock, reset and register port
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [31:0] regRdata;
	// Quantities on the block's own clock
	logic signed [15:0] spd = 16'h05dc;
	logic signed [15:0] spdCmd = 16'hfed4;
	logic signed [15:0] trq = 16'h0064;
	logic [15:0] ang = 16'h0e0f;
	logic signed [31:0] posErr = 32'h0;
	logic [10:0] lv = 11'h0; // Same-clock flags
	logic incEnc = 1'b0;
	logic [15:0] pinReq = 16'h0; // Asked of the pin model
	logic [15:0] pins;
	// Outputs and bookkeeping
	logic [31:0] monitorValue;
	logic inPositionOut;
	logic reverseMode;
	logic [31:0] v;
	logic [7:0] cfg;
	logic [7:0] cfgTab [4] = '{8'h00, 8'h06, 8'h11, 8'h1f};
	int n_mismatch = 0;
	int samples_checked = 0;

	// Free-running clock, 100 ns period
	always #50 ref_clk = ~ref_clk;

	dsmm_pin_model pm (.pinReq(pinReq), .pinOut(pins));

	dsmm_monitor dut (
		.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .motorSpeed(spd), .speedCommand(spdCmd), .torquePercent(trq), .elecAngle(ang),
		.posErrorPulses(posErr), .dynBrakeOn(lv[0]), .gainModeOn(lv[1]), .motorPowerOn(lv[2]),
		.servoAlarmOut(lv[3]), .rotationDetectOut(lv[4]), .brakeInterlockOut(lv[5]), .speedCoincideOut(lv[6]),
		.encOutA(lv[7]), .encOutB(lv[8]), .encOutC(lv[9]), .incrementalEnc(incEnc), .servoOnCmd(lv[10]),
		.dirPin(pins[0]), .fwdTorqueLimitIn(pins[1]), .revTorqueLimitIn(pins[2]), .encU(pins[3]), .encV(pins[4]),
		.encW(pins[5]), .propControlIn(pins[6]), .fwdOvertravelIn(pins[7]), .revOvertravelIn(pins[8]),
		.absDataRequestIn(pins[9]), .refPulseIn(pins[10]), .pulseSignIn(pins[11]), .errorClearIn(pins[12]),
		.extEncA(pins[13]), .extEncB(pins[14]), .extEncC(pins[15]), .monitorValue(monitorValue),
		.inPositionOut(inPositionOut), .reverseMode(reverseMode)
	);

	// Verdict and end of run
	task automatic end_sim();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Single compare for every result
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask

	// One-cycle read strobe; data taken in the following cycle only
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 v = regRdata;
	endtask

	// Select a monitor, let it settle, check word and selection state
	task automatic mon(input logic [3:0] s, input logic [31:0] m, input logic [31:0] e, input logic [1:0] st);
		wr(8'h00, {28'h0, s});
		repeat (3) @(posedge ref_clk);
		rd(8'h0c);
		chk(v & m, e);
		chk(monitorValue & m, e);
		rd(8'h10);
		chk({30'h0, v[1:0]}, {30'h0, st});
	endtask

	// Pin pulse long enough to pass the synchroniser filter
	task automatic pin_pulse(input int k);
		@(posedge ref_clk);
		pinReq[k] <= 1'b1;
		repeat (4) @(posedge ref_clk);
		pinReq[k] <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask

	// Error step then look at the in-position output
	task automatic inpos(input logic signed [31:0] e, input logic x);
		@(posedge ref_clk);
		posErr <= e;
		@(posedge ref_clk);
		#1 chk({31'h0, inPositionOut}, {31'h0, x});
	endtask

	// Expected internal flag word; status bit 5 assumes zero error, so in position
	function automatic logic [31:0] flags(input logic [7:0] c);
		flags = {12'h0, c[0] ? 1'b0 : pins[9], pins[8:6], lv[10], incEnc ? pins[5:3] : 3'h0, lv[9:7], lv[2],
			pins[2], c[4] | pins[1], lv[1], c[0] | lv[6], c[2] ? lv[5] : lv[4], c[1] | pins[0], lv[0], lv[3]};
	endfunction

	// Hang guard, far beyond the expected few hundred cycles
	initial begin
		#2000000;
		n_mismatch++;
		end_sim();
	end

	// Main sequence
	initial begin
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		rd(8'h04);
		chk(v, 32'h0);
		rd(8'h08);
		chk(v, 32'h1);
		wr(8'h14, 32'hffffffff);
		rd(8'h14);
		chk(v, 32'h0);
		$display("test reset done");
		// Position type
		wr(8'h04, 32'h1);
		repeat (5) pin_pulse(10);
		mon(4'h9, 32'hffff, 32'h5, 2'h0);
		pin_pulse(3);
		repeat (3) begin
			@(posedge ref_clk);
			lv[7] <= ~lv[7];
			@(posedge ref_clk);
			lv[7] <= ~lv[7];
		end
		mon(4'h3, 32'hffff, 32'h3, 2'h0);
		pin_pulse(3);
		mon(4'h3, 32'hffff, 32'h0, 2'h0);
		@(posedge ref_clk);
		posErr <= 32'sh4d2;
		mon(4'h8, 32'hffffffff, 32'h4d2, 2'h0);
		wr(8'h04, 32'h9);
		mon(4'h8, 32'hffffffff, 32'hc, 2'h0);
		@(posedge ref_clk);
		posErr <= -32'sh4d2;
		mon(4'h8, 32'hffffffff, 32'hfffffff4, 2'h0);
		@(posedge ref_clk);
		pinReq <= 16'h5400;
		mon(4'h6, 32'hffffffff, 32'h2005, 2'h0);
		mon(4'h1, 32'hffffffff, 32'h0, 2'h1);
		wr(8'h08, 32'h5);
		inpos(32'sh5, 1'b1);
		inpos(-32'sh5, 1'b1);
		inpos(32'sh6, 1'b0);
		inpos(-32'sh6, 1'b0);
		wr(8'h08, 32'h1);
		inpos(32'sh1, 1'b1);
		inpos(32'sh2, 1'b0);
		$display("test position type done");
		// Speed/torque type
		wr(8'h04, 32'h0);
		mon(4'h0, 32'hffff, 32'h05dc, 2'h0);
		mon(4'h1, 32'hffff, 32'hfed4, 2'h0);
		mon(4'h2, 32'hffff, 32'h0064, 2'h0);
		mon(4'h4, 32'hffff, 32'h0e0f, 2'h0);
		mon(4'h6, 32'hffffffff, 32'h0, 2'h1);
		mon(4'h8, 32'hffffffff, 32'h0, 2'h1);
		mon(4'h7, 32'hffffffff, 32'h0, 2'h2);
		wr(8'h00, 32'h0);
		@(posedge ref_clk);
		spd <= 16'h0123;
		repeat (3) @(posedge ref_clk);
		rd(8'h0c);
		chk(v & 32'hffff, 32'h0123);
		$display("test speed type done");
		// Flag words across configurations and level patterns
		@(posedge ref_clk);
		posErr <= 32'sh0;
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			lv <= i[0] ? 11'h2aa : 11'h555;
			pinReq <= i[0] ? 16'h5555 : 16'haaaa;
			incEnc <= i[1];
			cfg = cfgTab[i];
			wr(8'h04, {24'h0, cfg});
			repeat (6) @(posedge ref_clk);
			mon(4'h5, 32'hffffffff, flags(cfg), 2'h0);
			chk({31'h0, reverseMode}, {31'h0, cfg[1] | pins[0]});
		end
		$display("test flag words done");
		end_sim();
	end
endmodule
`default_nettype wire
